/* logic/atx_defs.svh */
// Timing constants and limits for the parallel host port block
`ifndef ATX_DEFS_SVH
`define ATX_DEFS_SVH

// Logic clock period
`define ATX_CLK_NS        25
// Cycle rounding: minimums up, maximums down but never below one cycle
`define ATX_CEIL(ns)      (((ns) + `ATX_CLK_NS - 1) / `ATX_CLK_NS)
`define ATX_FLOOR1(ns)    (((ns) < `ATX_CLK_NS) ? 1 : ((ns) / `ATX_CLK_NS))

// PIO wait-state limit
`define ATX_IORDY_MAX_NS  1250
`define ATX_IORDY_MAX_CYC `ATX_FLOOR1(`ATX_IORDY_MAX_NS)
// Multiword DMA: strobe to request drop, acknowledge to bus release
`define ATX_DMARQ_OFF_NS  35
`define ATX_DMARQ_OFF_CYC `ATX_FLOOR1(`ATX_DMARQ_OFF_NS)
`define ATX_MW_REL_NS     25
`define ATX_MW_REL_CYC    `ATX_FLOOR1(`ATX_MW_REL_NS)
// Ultra DMA: final strobe after pause, strobe pin release at end
`define ATX_RFS_MIN_NS    50
`define ATX_RFS_CYC       `ATX_FLOOR1(`ATX_RFS_MIN_NS)
`define ATX_IORDYZ_NS     20
`define ATX_IORDYZ_CYC    `ATX_FLOOR1(`ATX_IORDYZ_NS)

// Ultra DMA strobe cycle and two-cycle minimums per mode
`define ATX_TCYC_M0_NS    112
`define ATX_TCYC_M1_NS    73
`define ATX_TCYC_M2_NS    54
`define ATX_TCYC_M3_NS    39
`define ATX_TCYC_M4_NS    25
`define ATX_T2CYC_M0_NS   230
`define ATX_T2CYC_M1_NS   154
`define ATX_T2CYC_M2_NS   115
`define ATX_T2CYC_M3_NS   86
`define ATX_T2CYC_M4_NS   57
// Highest supported Ultra DMA mode
`define ATX_UDMA_TOP      4

`endif

/* logic/atx_pkg.sv */
// Types shared by the parallel host port block
package atx_pkg;
   // Selected Ultra DMA mode
   typedef logic [2:0] atx_mode_t;
   // Port sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PIO_RD,
      ST_MW,
      ST_UD_ARM,
      ST_UD_RUN,
      ST_UD_TERM
   } atx_state_t;
endpackage

/* logic/atx_buf.sv */
// Small ring buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module atx_buf #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   // Fill side
   input  wire logic [WIDTH-1:0] in_data_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   // Drain side
   output logic      [WIDTH-1:0] out_data_out,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);

   // Pointers need a power of two depth
   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
         $error("atx_buf: DEPTH must be a power of two of at least 2");
      end
   end

   logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
   logic [AW-1:0]    wr_q, wr_d;     // Write pointer
   logic [AW-1:0]    rd_q, rd_d;     // Read pointer
   logic [AW:0]      cnt_q, cnt_d;   // Fill level
   logic             push, pop;

   assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_out = (cnt_q != '0);
   assign out_data_out  = mem_q[rd_q];
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;

   // Pointer and level next values
   always_comb begin
      wr_d  = push ? wr_q + 1'b1 : wr_q;
      rd_d  = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   // Pointer registers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage has no reset; level guards stale words
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_q[wr_q] <= in_data_in;
      end
   end
endmodule
`default_nettype wire

/* logic/atx_port.sv */
// Device end of the parallel host port: PIO, multiword and Ultra DMA data-in
// Notes on behaviour
// R1: Host spaces PIO strobes 120 ns apart.
// R2: Host address setup 25 ns, hold 10 ns.
// R3: IORDY wait ends with data, at most 1250 ns.
// R4: Host spaces multiword strobes 120 ns apart.
// R5: Host strobe low 70 ns, high 25 ns.
// R6: Host acknowledge wraps each multiword strobe.
// R7: Drop DMA request within 35 ns of last strobe.
// R8: Release data bus within 25 ns of acknowledge.
// R9: Ultra DMA modes 0 to 4 supported.
// R10: Strobe half and full periods meet mode minimum.
// R11: Host acknowledge precedes burst start by 20 ns.
// R12: Slow-pausing host still accepts two words.
// R13: Final strobe within limit after host pause.
// R14: Host waits ready-to-pause time before stopping.
// R15: Release strobe pin within 20 ns of acknowledge.
// R16: Host stop precedes burst, terminates when reasserted.
// R17: Toggle strobe per word, both edges carry data.
// R18: Times become cycle counts by selected mode.
`include "atx_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module atx_port #(
   parameter int BUF_DEPTH = 2
) (
   // Clocks and reset
   input  wire logic              sys_clk_in,
   input  wire logic              link_clk_in,
   input  wire logic              rst_n_in,
   // Word source on the link clock
   input  wire logic [15:0]       src_word_in,
   input  wire logic              src_valid_in,
   output logic                   src_ready_out,
   // Transfer control
   input  wire atx_pkg::atx_mode_t udma_mode_in,
   input  wire logic              udma_en_in,
   input  wire logic              dma_req_in,
   // PIO user side
   input  wire logic [15:0]       pio_rd_data_in,
   input  wire logic              pio_rd_valid_in,
   output logic                   pio_rd_strobe_out,
   output logic                   pio_wr_strobe_out,
   output logic [15:0]            pio_wr_data_out,
   // Host port pins
   input  wire logic              dior_n_in,
   input  wire logic              diow_n_in,
   input  wire logic              dmack_n_in,
   input  wire logic [15:0]       dd_in,
   output logic [15:0]            dd_out,
   output logic                   dd_oe_out,
   output logic                   dmarq_out,
   output logic                   iordy_out,
   output logic                   iordy_oe_out
);
   import atx_pkg::*;

   // Elaboration check on buffer size
   initial begin
      if (BUF_DEPTH < 2) begin
         $error("atx_port: BUF_DEPTH below 2 cannot absorb a stall");
      end
   end

   // Strobe half period per mode; unsupported modes fall back to mode 0
   function automatic logic [5:0] atx_hp(input atx_mode_t m);
      int c;
      int t;
      case (m)
         3'h1:    begin c = `ATX_TCYC_M1_NS; t = `ATX_T2CYC_M1_NS; end
         3'h2:    begin c = `ATX_TCYC_M2_NS; t = `ATX_T2CYC_M2_NS; end
         3'h3:    begin c = `ATX_TCYC_M3_NS; t = `ATX_T2CYC_M3_NS; end
         3'h4:    begin c = `ATX_TCYC_M4_NS; t = `ATX_T2CYC_M4_NS; end
         default: begin c = `ATX_TCYC_M0_NS; t = `ATX_T2CYC_M0_NS; end
      endcase
      c = `ATX_CEIL(c);
      t = (t + 2 * `ATX_CLK_NS - 1) / (2 * `ATX_CLK_NS);
      return (c > t) ? 6'(c) : 6'(t);
   endfunction

   // ---------------- Link domain: toggle handshake sender ----------------
   logic [15:0] lnk_word_q, lnk_word_d;  // Held word during crossing
   logic        lnk_req_q, lnk_req_d;    // Request toggle
   logic        lnk_ack1_q, lnk_ack2_q;  // Acknowledge synchroniser
   logic        lnk_busy;
   logic        sys_ack_q, sys_ack_d;    // Acknowledge toggle, system side

   assign lnk_busy      = (lnk_req_q != lnk_ack2_q);
   assign src_ready_out = ~lnk_busy;

   // Take a new word only after the last one was acknowledged
   always_comb begin
      lnk_word_d = lnk_word_q;
      lnk_req_d  = lnk_req_q;
      if (src_valid_in && !lnk_busy) begin
         lnk_word_d = src_word_in;
         lnk_req_d  = ~lnk_req_q;
      end
   end

   // Link registers; acknowledge crosses in on two flops
   always_ff @(posedge link_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lnk_word_q <= 16'h0000;
         lnk_req_q  <= 1'b0;
         lnk_ack1_q <= 1'b0;
         lnk_ack2_q <= 1'b0;
      end else begin
         lnk_word_q <= lnk_word_d;
         lnk_req_q  <= lnk_req_d;
         lnk_ack1_q <= sys_ack_q;
         lnk_ack2_q <= lnk_ack1_q;
      end
   end

   // ---------------- System domain: pin and request synchronisers --------
   logic [19:0] syn1_q, syn2_q;  // {dd, dmack, diow, dior, link req}
   logic        dior_p_q, diow_p_q;  // Previous synced strobes
   logic        s_dior_n, s_diow_n, s_dmack_n;
   logic [15:0] s_dd;

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         syn1_q   <= 20'hFFFFE;
         syn2_q   <= 20'hFFFFE;
         dior_p_q <= 1'b1;
         diow_p_q <= 1'b1;
      end else begin
         syn1_q   <= {dd_in, dmack_n_in, diow_n_in, dior_n_in, lnk_req_q};
         syn2_q   <= syn1_q;
         dior_p_q <= syn2_q[1];
         diow_p_q <= syn2_q[2];
      end
   end

   assign s_dior_n  = syn2_q[1];  // Also ready-to-receive, low active, in Ultra DMA
   assign s_diow_n  = syn2_q[2];  // Also the host stop line in Ultra DMA
   assign s_dmack_n = syn2_q[3];
   assign s_dd      = syn2_q[19:4];

   // ---------------- Crossing receiver into the buffer -------------------
   logic        buf_in_ready, buf_out_valid, pop;
   logic [15:0] buf_out_data;
   logic        xfer_pend;

   // Word stays held on the link side until the toggle returns
   assign xfer_pend = (syn2_q[0] != sys_ack_q);
   assign sys_ack_d = (xfer_pend && buf_in_ready) ? ~sys_ack_q : sys_ack_q;

   atx_buf #(.WIDTH(16), .DEPTH(BUF_DEPTH)) u_buf (
      .clk_in        (sys_clk_in),
      .rst_n_in      (rst_n_in),
      .in_data_in    (lnk_word_q),
      .in_valid_in   (xfer_pend),
      .in_ready_out  (buf_in_ready),
      .out_data_out  (buf_out_data),
      .out_valid_out (buf_out_valid),
      .out_ready_in  (pop)
   );

   // ---------------- Port sequencer ---------------------------------------
   atx_state_t  st_q, st_d;
   logic [15:0] dd_q, dd_d;          // Driven data
   logic        dd_oe_q, dd_oe_d;    // Data bus enable
   logic        dmarq_q, dmarq_d;    // DMA request
   logic        io_oe_q, io_oe_d;    // Ready/strobe pin enable
   logic        io_val_q, io_val_d;  // Ready/strobe pin level
   logic [5:0]  cnt_q, cnt_d;        // Wait and half-period counter
   logic        ld_q, ld_d;          // Word loaded for next strobe edge
   logic        rd_stb_q, rd_stb_d;  // PIO read pulse
   logic        wr_stb_q, wr_stb_d;  // PIO write pulse
   logic [15:0] wr_q, wr_d;          // PIO write word
   logic [5:0]  hp_now;
   logic        rd_fall, rd_rise, wr_rise, tog;

   assign hp_now  = atx_hp(udma_mode_in);  // R9 R18
   assign rd_fall = dior_p_q & ~s_dior_n;
   assign rd_rise = ~dior_p_q & s_dior_n;
   assign wr_rise = ~diow_p_q & s_diow_n;
   assign tog     = (io_val_d != io_val_q);

   // Next state of the sequencer
   always_comb begin
      st_d     = st_q;
      dd_d     = dd_q;
      dd_oe_d  = dd_oe_q;
      dmarq_d  = dmarq_q;
      io_oe_d  = io_oe_q;
      io_val_d = io_val_q;
      cnt_d    = (cnt_q == 6'h3F) ? cnt_q : cnt_q + 6'h01;
      ld_d     = ld_q;
      pop      = 1'b0;
      rd_stb_d = 1'b0;
      wr_stb_d = 1'b0;
      wr_d     = wr_q;
      case (st_q)
         ST_IDLE: begin
            // Bus and ready pin left to the host
            dd_oe_d  = 1'b0;
            io_oe_d  = 1'b0;
            io_val_d = 1'b0;
            if (rd_fall && s_dmack_n) begin
               // PIO read; hold ready low while data is not there
               rd_stb_d = 1'b1;
               dd_oe_d  = 1'b1;
               dd_d     = pio_rd_data_in;
               io_oe_d  = ~pio_rd_valid_in;  // R3
               cnt_d    = 6'h00;
               st_d     = ST_PIO_RD;
            end else if (wr_rise && s_dmack_n) begin
               // PIO write word taken at strobe release
               wr_stb_d = 1'b1;
               wr_d     = s_dd;
            end else if (dma_req_in && buf_out_valid) begin
               dmarq_d = 1'b1;
               st_d    = udma_en_in ? ST_UD_ARM : ST_MW;
            end
         end
         ST_PIO_RD: begin
            // Data loads in the same edge that frees the ready pin
            if (io_oe_q && (pio_rd_valid_in || cnt_q >= 6'(`ATX_IORDY_MAX_CYC - 1))) begin
               io_oe_d = 1'b0;  // R3
               dd_d    = pio_rd_data_in;  // R3
            end
            if (s_dior_n) begin
               dd_oe_d = 1'b0;
               io_oe_d = 1'b0;
               st_d    = ST_IDLE;
            end
         end
         ST_MW: begin
            if (!s_dmack_n && rd_fall) begin
               dd_oe_d = 1'b1;
               dd_d    = buf_out_data;
               // Request dropped on the last strobe the source allows
               if (!dma_req_in) begin
                  dmarq_d = 1'b0;  // R7
               end
            end
            if (!s_dmack_n && rd_rise) begin
               pop = buf_out_valid;
            end
            if (s_dmack_n) begin
               dd_oe_d = 1'b0;  // R8
               if (!dmarq_q) begin
                  st_d = ST_IDLE;
               end
            end
         end
         ST_UD_ARM: begin
            // Wait for acknowledge, stop released and host ready
            if (!s_dmack_n && !s_diow_n && !s_dior_n) begin
               io_oe_d  = 1'b1;
               io_val_d = 1'b0;
               dd_oe_d  = 1'b1;
               ld_d     = 1'b0;
               cnt_d    = 6'h00;
               st_d     = ST_UD_RUN;
            end
         end
         ST_UD_RUN: begin
            if (s_diow_n) begin
               // Host stop ends the burst; a loaded word is dropped
               dmarq_d = 1'b0;
               ld_d    = 1'b0;
               st_d    = ST_UD_TERM;
            end else begin
               if (!ld_q && buf_out_valid) begin
                  // Load one cycle ahead of the edge for setup
                  dd_d = buf_out_data;
                  pop  = 1'b1;
                  ld_d = 1'b1;
               end
               // Pause while host ready is negated
               if (ld_q && !s_dior_n && cnt_q >= hp_now - 6'h01) begin  // R13
                  io_val_d = ~io_val_q;  // R17
                  ld_d     = 1'b0;
                  cnt_d    = 6'h00;  // R10
               end
            end
         end
         ST_UD_TERM: begin
            if (s_dmack_n) begin
               dd_oe_d  = 1'b0;
               io_oe_d  = 1'b0;  // R15
               io_val_d = 1'b0;
               st_d     = ST_IDLE;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q      <= ST_IDLE;
         dd_q      <= 16'h0000;
         dd_oe_q   <= 1'b0;
         dmarq_q   <= 1'b0;
         io_oe_q   <= 1'b0;
         io_val_q  <= 1'b0;
         cnt_q     <= 6'h00;
         ld_q      <= 1'b0;
         rd_stb_q  <= 1'b0;
         wr_stb_q  <= 1'b0;
         wr_q      <= 16'h0000;
         sys_ack_q <= 1'b0;
      end else begin
         st_q      <= st_d;
         dd_q      <= dd_d;
         dd_oe_q   <= dd_oe_d;
         dmarq_q   <= dmarq_d;
         io_oe_q   <= io_oe_d;
         io_val_q  <= io_val_d;
         cnt_q     <= cnt_d;
         ld_q      <= ld_d;
         rd_stb_q  <= rd_stb_d;
         wr_stb_q  <= wr_stb_d;
         wr_q      <= wr_d;
         sys_ack_q <= sys_ack_d;
      end
   end

   // Outputs straight from flops
   assign dd_out            = dd_q;
   assign dd_oe_out         = dd_oe_q;
   assign dmarq_out         = dmarq_q;
   assign iordy_out         = io_val_q;
   assign iordy_oe_out      = io_oe_q;
   assign pio_rd_strobe_out = rd_stb_q;
   assign pio_wr_strobe_out = wr_stb_q;
   assign pio_wr_data_out   = wr_q;

   // ---------------- Checks ----------------------------------------------
   a_iordy_wait_cap: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R3
      (st_q == ST_PIO_RD && io_oe_q) |-> cnt_q < 6'(`ATX_IORDY_MAX_CYC))
      else $error("ready held low too long");
   a_dmarq_last_drop: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R7
      (st_q == ST_MW && !s_dmack_n && rd_fall && !dma_req_in) |-> ##[1:1] !dmarq_q)
      else $error("request not dropped after last strobe");
   a_mw_bus_release: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R8
      (st_q == ST_MW && s_dmack_n) |=> !dd_oe_q)
      else $error("data bus held after acknowledge");
   a_mode_period_map: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R9
      (udma_mode_in == 3'h4 |-> hp_now == 6'h02) and (udma_mode_in == 3'h0 |-> hp_now == 6'h05))
      else $error("mode period table wrong");
   a_strobe_half_min: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R10
      (st_q == ST_UD_RUN && tog) |-> (cnt_q >= hp_now - 6'h01))
      else $error("strobe half period short");
   a_pause_holds: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R13
      (st_q == ST_UD_RUN && s_dior_n) |=> $stable(io_val_q))
      else $error("strobe toggled during pause");
   a_term_release: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R15
      (st_q == ST_UD_TERM && s_dmack_n) |=> (!io_oe_q && !dd_oe_q))
      else $error("strobe pin not released");
   a_strobe_data: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R17
      ($changed(io_val_q) && io_oe_q) |-> (dd_oe_q && $stable(dd_q)))
      else $error("data moved with strobe edge");
endmodule
`default_nettype wire

/* tb/atx_host_model.sv */
// Host controller model that drives the parallel port pins
`timescale 1ns/10ps
`default_nettype none
module atx_host_model (
   // Clock
   input  wire logic        clk_in,
   // Pins toward the device
   output logic             dior_n_out,
   output logic             diow_n_out,
   output logic             dmack_n_out,
   output logic [15:0]      dd_out,
   // Pins from the device
   input  wire logic [15:0] dd_in,
   input  wire logic        dmarq_in,
   input  wire logic        iordy_in,
   input  wire logic        iordy_oe_in
);
   logic [15:0] got_q[$];   // Words latched on strobe edges
   logic        strb_q;     // Strobe level last seen
   logic        drv;        // Host drives the data bus
   logic [15:0] wd, junk;   // Write word; idle pattern on a released bus
   int          cnt, prev, ntog, min_half, min_full, now, last_tog;
   logic        iordy_w;    // Pin level with pull-up
   assign iordy_w = iordy_oe_in ? iordy_in : 1'b1;
   // One driver for the bus, so a write word is never overwritten at its edge
   assign dd_out  = drv ? wd : junk;
   initial begin
      {dior_n_out, diow_n_out, dmack_n_out, drv} = 4'hE;
      {wd, junk} = {16'h0000, 16'h5A5A};
      {strb_q, cnt, prev, ntog, now, last_tog} = '0;
   end
   // Released bus changes every cycle so a stale value never passes
   always @(negedge clk_in) begin
      now++;
      junk <= ~junk;
      if (!iordy_oe_in) begin
         strb_q = 1'b0;
         ntog = 0;
      end else begin
         cnt++;
         if (iordy_in !== strb_q) begin
            got_q.push_back(dd_in);
            if (ntog >= 1 && cnt < min_half) min_half = cnt;
            if (ntog >= 2 && cnt + prev < min_full) min_full = cnt + prev;
            prev = cnt;
            cnt = 0;
            ntog++;
            strb_q = iordy_in;
            last_tog = now;
         end
      end
   end
   // Acknowledge level, set between strobes
   task automatic ack(input logic v);
      dmack_n_out = v;
      @(negedge clk_in);
   endtask
   // PIO write: 75 ns low, 75 ns high, data held past the rise
   task automatic pio_wr(input logic [15:0] w);
      drv = 1'b1;
      wd = w;
      diow_n_out = 1'b0;
      repeat (3) @(negedge clk_in);
      diow_n_out = 1'b1;
      repeat (3) @(negedge clk_in);
      drv = 1'b0;
   endtask
   // PIO read, stretched while the ready line is held low
   task automatic pio_rd(output logic [15:0] d, output int waited);
      dior_n_out = 1'b0;
      waited = 0;
      repeat (3) @(negedge clk_in);
      while (!iordy_w && waited < 200) begin
         @(negedge clk_in);
         waited++;
      end
      d = dd_in;
      dior_n_out = 1'b1;
      repeat (2) @(negedge clk_in);
   endtask
   // One multiword read strobe, 125 ns start to start
   task automatic mw_rd(output logic [15:0] d);
      dior_n_out = 1'b0;
      repeat (3) @(negedge clk_in);
      d = dd_in;
      dior_n_out = 1'b1;
      repeat (2) @(negedge clk_in);
   endtask
   // Ultra DMA data-in burst with two pauses, one mid-burst and one before the host stop
   task automatic ud_rd(input int n, output int late);
      int k, tp;
      {min_half, min_full, late, k} = {32'd999, 32'd999, 32'd0, 32'd0};
      got_q.delete();
      diow_n_out = 1'b1;
      while (!dmarq_in && k < 400) begin
         @(negedge clk_in);
         k++;
      end
      dmack_n_out = 1'b0;
      @(negedge clk_in);
      diow_n_out = 1'b0;
      dior_n_out = 1'b0;
      for (k = 0; got_q.size() < 3 && k < 2000; k++) @(negedge clk_in);
      dior_n_out = 1'b1;
      tp = now;
      repeat (10) @(negedge clk_in);
      late = last_tog - tp;
      dior_n_out = 1'b0;
      for (k = 0; got_q.size() < n && k < 2000; k++) @(negedge clk_in);
      dior_n_out = 1'b1;
      repeat (8) @(negedge clk_in);
      diow_n_out = 1'b1;
      for (k = 0; dmarq_in && k < 100; k++) @(negedge clk_in);
      dmack_n_out = 1'b1;
      repeat (3) @(negedge clk_in);
   endtask
endmodule
`default_nettype wire

/* tb/atx_port_tb_top.sv */
// Self-checking bench for the parallel host port device end
`include "atx_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module atx_port_tb_top;
   import atx_pkg::*;
   logic        sys_clk, link_clk, rst_n, src_valid, src_ready, udma_en, dma_req;
   logic        rd_valid, rd_stb, wr_stb, dior_n, diow_n, dmack_n, dd_oe, dmarq;
   logic        iordy, iordy_oe;
   logic [15:0] src_word, rd_data, wr_data, h_dd, d_dd, dd_w, wr_word;
   atx_mode_t   mode;
   int          n_errors, checked, wr_cnt, rd_cnt;
   // Shared data wire: the device wins while its enable is high
   assign dd_w = dd_oe ? d_dd : h_dd;
   atx_port dut (.sys_clk_in(sys_clk), .link_clk_in(link_clk), .rst_n_in(rst_n),
      .src_word_in(src_word), .src_valid_in(src_valid), .src_ready_out(src_ready),
      .udma_mode_in(mode), .udma_en_in(udma_en), .dma_req_in(dma_req),
      .pio_rd_data_in(rd_data), .pio_rd_valid_in(rd_valid), .pio_rd_strobe_out(rd_stb),
      .pio_wr_strobe_out(wr_stb), .pio_wr_data_out(wr_data), .dior_n_in(dior_n),
      .diow_n_in(diow_n), .dmack_n_in(dmack_n), .dd_in(dd_w), .dd_out(d_dd),
      .dd_oe_out(dd_oe), .dmarq_out(dmarq), .iordy_out(iordy), .iordy_oe_out(iordy_oe));
   atx_host_model host (.clk_in(sys_clk), .dior_n_out(dior_n), .diow_n_out(diow_n),
      .dmack_n_out(dmack_n), .dd_out(h_dd), .dd_in(dd_w), .dmarq_in(dmarq),
      .iordy_in(iordy), .iordy_oe_in(iordy_oe));
   // Clocks: link phase offset keeps the domains unrelated
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #80 link_clk = ~link_clk;
   end
   // Count user-side PIO pulses mid-cycle, away from the launching edge
   always @(negedge sys_clk) begin
      if (wr_stb === 1'b1) begin
         wr_cnt++;
         wr_word = wr_data;
      end
      if (rd_stb === 1'b1) rd_cnt++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One word across the link handshake
   task automatic push(input logic [15:0] w);
      int k;
      @(negedge link_clk);
      src_word = w;
      src_valid = 1'b1;
      k = 0;
      do begin
         @(posedge link_clk);
         k++;
      end while (src_ready !== 1'b1 && k < 100);
      @(negedge link_clk);
      src_valid = 1'b0;
   endtask
   task automatic t_pio_wr();
      host.pio_wr(16'hC3A5);
      host.pio_wr(16'h3C5A);
      repeat (4) @(negedge sys_clk);
      chk(wr_cnt, 2);
      chk(wr_word, 16'h3C5A);
   endtask
   task automatic t_pio_rd(input logic late_data);
      logic [15:0] d;
      int          w;
      rd_valid = 1'b0;
      fork
         begin
            repeat (12) @(negedge sys_clk);
            rd_data = late_data ? 16'h1234 : 16'h5678;
            rd_valid = late_data;
         end
         host.pio_rd(d, w);
      join
      chk(d, late_data ? 16'h1234 : 16'h5678);
      chk(w > 0 && w <= `ATX_IORDY_MAX_CYC, 1);
   endtask
   task automatic t_mw();
      logic [15:0] d;
      udma_en = 1'b0;
      push(16'h0BEE);
      push(16'h0CAF);
      dma_req = 1'b1;
      for (int k = 0; dmarq !== 1'b1 && k < 200; k++) @(negedge sys_clk);
      host.ack(1'b0);
      host.mw_rd(d);
      chk(d, 16'h0BEE);
      dma_req = 1'b0;
      host.mw_rd(d);
      chk(d, 16'h0CAF);
      chk(dmarq, 1'b0);
      host.ack(1'b1);
      repeat (2) @(negedge sys_clk);
      chk(dd_oe, 1'b0);
   endtask
   task automatic t_udma(input int m, input int tc, input int t2);
      int late;
      mode = 3'(m);
      udma_en = 1'b1;
      push(16'hD000 | 16'(m << 4));
      push(16'hD001 | 16'(m << 4));
      dma_req = 1'b1;
      fork
         for (int i = 2; i < 5; i++) push(16'hD000 | 16'(m << 4) | 16'(i));
      join_none
      host.ud_rd(5, late);
      dma_req = 1'b0;
      chk(host.got_q.size(), 5);
      foreach (host.got_q[i]) chk(host.got_q[i], 16'hD000 | 16'(m << 4) | 16'(i));
      chk(host.min_half >= `ATX_CEIL(tc), 1);
      chk(host.min_full >= `ATX_CEIL(t2), 1);
      chk(late <= 2 + `ATX_RFS_CYC, 1);
      chk({iordy_oe, dd_oe, dmarq}, 3'h0);
   endtask
   task automatic results();
      if (n_errors == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Watchdog well beyond the expected run of a few tens of microseconds
   initial begin
      #400000;
      n_errors++;
      results();
   end
   initial begin
      int tcs[5] = '{`ATX_TCYC_M0_NS, `ATX_TCYC_M1_NS, `ATX_TCYC_M2_NS,
                     `ATX_TCYC_M3_NS, `ATX_TCYC_M4_NS};
      int t2s[5] = '{`ATX_T2CYC_M0_NS, `ATX_T2CYC_M1_NS, `ATX_T2CYC_M2_NS,
                     `ATX_T2CYC_M3_NS, `ATX_T2CYC_M4_NS};
      {rst_n, src_valid, udma_en, dma_req, rd_valid} = 5'h01;
      {src_word, rd_data, mode} = '0;
      {n_errors, checked, wr_cnt, rd_cnt} = '0;
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      t_pio_wr();
      t_pio_rd(1'b1);
      t_pio_rd(1'b0);
      chk(rd_cnt, 2);
      t_mw();
      for (int m = 0; m <= `ATX_UDMA_TOP; m++) t_udma(m, tcs[m], t2s[m]);
      results();
   end
endmodule
`default_nettype wire
